// *** sbrg_chk.sv ***
// Checker for sbrg_top: read port, tick spacing, restart and vote timing.
// Assumes it is bound to sbrg_top and sees only its ports.
`timescale 1ns/1ps
module sbrg_chk
   import sbrg_pkg::*;
(
   // Clock, reset, register port
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // Serial side
   input wire logic i_receive_line,
   input wire logic o_bit_tick,
   input wire logic o_sample_tick,
   input wire logic o_rx_level
);
   logic [7:0] lo_reg;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) lo_reg <= DIV_RESET;
      else if (i_wr && i_addr == ADDR_DIV_LOW) lo_reg <= i_wdata;
   end
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read cycle");
   a_low_readback: assert property ($past(i_rd) && $past(i_addr) == ADDR_DIV_LOW |->
      o_rdata == lo_reg) else $error("low divisor readback wrong");
   a_rate_bit2: assert property ($past(i_rd) && $past(i_addr) == ADDR_RATE_CTRL |->
      !o_rdata[2]) else $error("rate control bit 2 set");
   a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) > ADDR_STATUS |->
      o_rdata == 8'h00) else $error("unmapped read not zero");
   a_tick_gap: assert property (o_bit_tick |=> !o_bit_tick [*3])
      else $error("bit ticks too close");
   a_div_restart: assert property (i_wr && (i_addr == ADDR_DIV_LOW ||
      i_addr == ADDR_DIV_HIGH) |-> ##1 !o_bit_tick [*4]) else $error("no divider restart");
   a_vote_sync: assert property ($changed(o_rx_level) && !$past(i_wr) && !$past(i_wr, 2) |->
      $past(o_sample_tick) || $past(o_sample_tick, 2)) else $error("level moved without vote");
   a_reset_vals: assert property ($rose(i_rst_b) |-> o_rx_level && !o_bit_tick &&
      o_rdata == 8'h00) else $error("reset outputs wrong");
endmodule
bind sbrg_top sbrg_chk i_chk (.i_clock, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .i_receive_line, .o_bit_tick, .o_sample_tick, .o_rx_level);

// *** sbrg_line_model.sv ***
// Remote transceiver model driving the receive line.
// Assumes level and spike requests change just after i_clock edges.
`timescale 1ns/1ps
module sbrg_line_model (
   // Requests and line
   input wire logic i_clock,
   input wire logic i_level,
   input wire logic i_glitch,
   output logic o_line
);
   initial o_line = 1'b1;
   // A spike inverts the line for one cycle
   always @(posedge i_clock) o_line <= i_level ^ i_glitch;
endmodule

// *** sbrg_pkg.sv ***
// Constants, register map and field layout for the serial bit-rate generator.
// Assumes a single 100 MHz core clock and a plain strobe register port.
// Overview of operation
// - Divider counts core clock cycles only
// - Three samples per bit, majority vote
// - Async 8-bit low speed: 64*(n+1)
// - Async 16-bit low speed: 16*(n+1)
// - Sync master: 4*(n+1), speed ignored
// - 16-bit divisor is high byte concatenated low
// - Divisor held in two byte registers
// - Rate control bit 2 reads zero
// - Divisor write restarts divider at once
// - Reset selects 8-bit, high byte ignored
package sbrg_pkg;
   localparam int ADDR_W = 3;
   localparam logic [ADDR_W-1:0] ADDR_TX_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_RX_CTRL = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_RATE_CTRL = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_DIV_HIGH = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_DIV_LOW = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h5;
   // Field positions
   localparam int TX_SYNC_BIT = 4;
   localparam int TX_HIGH_SPEED_BIT = 2;
   localparam int TX_CLOCK_MASTER_BIT = 7;
   localparam int RX_PORT_ENABLE_BIT = 7;
   localparam int RATE_WIDE_BIT = 3;
   localparam int RATE_POL_BIT = 5;
   // Writable masks and reset values
   localparam logic [7:0] TX_CTRL_RESET = 8'h00;
   localparam logic [7:0] RX_CTRL_RESET = 8'h00;
   localparam logic [7:0] RATE_CTRL_RESET = 8'h00;
   localparam logic [7:0] RATE_CTRL_MASK = 8'h3B;
   localparam logic [7:0] DIV_RESET = 8'h00;
   // Prescale terminal counts (prescale minus one)
   localparam logic [5:0] PRE_64 = 6'h3F;
   localparam logic [5:0] PRE_16 = 6'h0F;
   localparam logic [5:0] PRE_4 = 6'h03;
   // Counter clear values and the vote count of the third sample
   localparam logic [5:0] ZERO6 = 6'h00;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [1:0] VOTE_CNT_LAST = 2'h2;

   typedef struct packed {
      logic [7:0] tx_ctrl;
      logic [7:0] rx_ctrl;
      logic [7:0] rate_ctrl;
      logic [7:0] div_high;
      logic [7:0] div_low;
      logic [5:0] pre_cnt;
      logic [15:0] div_cnt;
      logic [2:0] rx_pipe;
      logic [2:0] samples;
      logic [1:0] vote_cnt;
      logic rx_level;
      logic bit_tick;
      logic sample_tick;
      logic [7:0] rdata;
   } sbrg_state_t;
endpackage

// *** sbrg_tb.sv ***
// Testbench for sbrg_top: rate table, restart, register reads, vote.
// Assumes checker and line model are compiled first.
`timescale 1ns/1ps
module testbench import sbrg_pkg::*;;
   logic i_clock = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic lvl = 1'b1, glt = 1'b0, line, o_bit_tick, o_sample_tick, o_rx_level;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [7:0] i_wdata = 8'h00, o_rdata, d;
   int n_errors = 0, n_checks = 0, t, f, s;
   // Rows {tx, rate, low, high} and bit period in cycles
   logic [31:0] rows [6] = '{32'h0000_0105, 32'h0400_0200, 32'h0008_0101,
      32'h0408_0300, 32'h1000_0400, 32'h1408_0001};
   int pers [6] = '{128, 48, 4128, 16, 20, 1028};
   always #5 i_clock = ~i_clock;
   sbrg_top i_dut (.i_clock, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_receive_line(line), .o_bit_tick, .o_sample_tick, .o_rx_level);
   sbrg_line_model i_far (.i_clock, .i_level(lvl), .i_glitch(glt), .o_line(line));
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic tick();
      t = 0;
      s = 0;
      do begin
         @(negedge i_clock);
         t++;
         s += (o_sample_tick === 1'b1);
      end while (o_bit_tick !== 1'b1 && t < 5000);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #500_000;
      n_errors++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd(ADDR_DIV_LOW);
      chk(16'(d), 16'(DIV_RESET));
      wr(ADDR_RX_CTRL, 8'h80);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_TX_CTRL, rows[i][31:24]);
         wr(ADDR_RATE_CTRL, rows[i][23:16]);
         wr(ADDR_DIV_HIGH, rows[i][7:0]);
         wr(ADDR_DIV_LOW, rows[i][15:8]);
         tick();
         tick();
         chk(16'(t), 16'(pers[i]));
         chk(16'(s), 16'h0003);
         $display("rate row %0d done", i);
      end
      tick();
      // Restart: one 4-cycle bit from the write, plus the output flop
      wr(ADDR_DIV_HIGH, 8'h00);
      tick();
      chk(16'(t), 16'h0005);
      tick();
      chk(16'(t), 16'h0004);
      wr(ADDR_RATE_CTRL, 8'hFF);
      rd(ADDR_RATE_CTRL);
      chk(16'(d), 16'(RATE_CTRL_MASK));
      rd(3'h7);
      chk(16'(d), 16'h0000);
      $display("register test done");
      wr(ADDR_TX_CTRL, 8'h00);
      wr(ADDR_RATE_CTRL, 8'h08);
      wr(ADDR_DIV_LOW, 8'h00);
      lvl <= 1'b0;
      repeat (60) @(negedge i_clock);
      chk(16'(o_rx_level), 16'h0000);
      // One-cycle spikes 17 cycles apart walk every phase of a 16-cycle bit
      f = 0;
      for (int k = 0; k < 16; k++) begin
         @(posedge i_clock);
         glt <= 1'b1;
         @(posedge i_clock);
         glt <= 1'b0;
         repeat (16) @(negedge i_clock) f += (o_rx_level !== 1'b0);
      end
      chk(16'(f), 16'h0000);
      @(posedge i_clock);
      lvl <= 1'b1;
      repeat (60) @(negedge i_clock);
      chk(16'(o_rx_level), 16'h0001);
      $display("vote test done");
      @(posedge i_clock);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd(ADDR_RATE_CTRL);
      chk(16'(d), 16'(RATE_CTRL_RESET));
      $display("reset test done");
      conclude();
   end
endmodule

// *** sbrg_top.sv ***
// Bit-rate divider and receive-line majority sampler with register port.
// Assumes inputs synchronous to i_clock; read data valid one cycle after strobe.
`timescale 1ns/1ps
module sbrg_top
   import sbrg_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // Register port
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Serial line
   input wire logic i_receive_line,
   output logic o_bit_tick,
   output logic o_sample_tick,
   output logic o_rx_level
);
   sbrg_state_t s_reg;
   sbrg_state_t s_next;

   function automatic logic majority(input logic [2:0] v);
      majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   logic wide;
   logic fast;
   logic sync_mode;
   logic [15:0] divisor;
   logic [5:0] prescale;
   logic pre_wrap;
   logic div_wrap;
   logic div_write;
   logic rx_sample;

   always_comb begin
      wide = s_reg.rate_ctrl[RATE_WIDE_BIT];
      fast = s_reg.tx_ctrl[TX_HIGH_SPEED_BIT];
      sync_mode = s_reg.tx_ctrl[TX_SYNC_BIT];
      divisor = wide ? {s_reg.div_high, s_reg.div_low} : {8'h00, s_reg.div_low};
      if (sync_mode) begin
         prescale = PRE_4;
      end else if (!wide && !fast) begin
         prescale = PRE_64;
      end else if (!wide || !fast) begin
         prescale = PRE_16;
      end else begin
         prescale = PRE_4;
      end
      div_write = i_wr && (i_addr == ADDR_DIV_HIGH || i_addr == ADDR_DIV_LOW);
      pre_wrap = s_reg.pre_cnt >= prescale;
      div_wrap = pre_wrap && (s_reg.div_cnt >= divisor);
      // Resampled line with polarity applied
      rx_sample = s_reg.rx_pipe[2] ^ s_reg.rate_ctrl[RATE_POL_BIT];
   end

   always_comb begin
      s_next = s_reg;
      s_next.bit_tick = 1'b0;
      s_next.sample_tick = 1'b0;
      if (i_wr) begin
         if (i_addr == ADDR_TX_CTRL) begin
            s_next.tx_ctrl = i_wdata;
         end else if (i_addr == ADDR_RX_CTRL) begin
            s_next.rx_ctrl = i_wdata;
         end else if (i_addr == ADDR_RATE_CTRL) begin
            s_next.rate_ctrl = i_wdata & RATE_CTRL_MASK;
         end else if (i_addr == ADDR_DIV_HIGH) begin
            s_next.div_high = i_wdata;
         end else if (i_addr == ADDR_DIV_LOW) begin
            s_next.div_low = i_wdata;
         end
      end
      if (i_rd) begin
         if (i_addr == ADDR_TX_CTRL) begin
            s_next.rdata = s_reg.tx_ctrl;
         end else if (i_addr == ADDR_RX_CTRL) begin
            s_next.rdata = s_reg.rx_ctrl;
         end else if (i_addr == ADDR_RATE_CTRL) begin
            s_next.rdata = s_reg.rate_ctrl;
         end else if (i_addr == ADDR_DIV_HIGH) begin
            s_next.rdata = s_reg.div_high;
         end else if (i_addr == ADDR_DIV_LOW) begin
            s_next.rdata = s_reg.div_low;
         end else if (i_addr == ADDR_STATUS) begin
            s_next.rdata = {5'h00, s_reg.rx_pipe[2], s_reg.samples[0], s_reg.rx_level};
         end else begin
            s_next.rdata = 8'h00;
         end
      end else begin
         s_next.rdata = 8'h00;
      end
      // Receive line pipeline, polarity applied after the resampling stage
      s_next.rx_pipe = {s_reg.rx_pipe[1:0], i_receive_line};
      if (div_write || !s_reg.rx_ctrl[RX_PORT_ENABLE_BIT]) begin
         s_next.pre_cnt = ZERO6;
         s_next.div_cnt = ZERO16;
         s_next.vote_cnt = 2'h0;
      end else begin
         if (s_reg.div_cnt == ZERO16 && s_reg.vote_cnt <= VOTE_CNT_LAST) begin
            s_next.samples = {s_reg.samples[1:0], rx_sample};
            s_next.sample_tick = 1'b1;
            s_next.vote_cnt = s_reg.vote_cnt + 2'h1;
            if (s_reg.vote_cnt == VOTE_CNT_LAST) begin
               s_next.rx_level = majority({s_reg.samples[1:0], rx_sample});
            end
         end
         if (pre_wrap) begin
            s_next.pre_cnt = ZERO6;
            // Bit boundary re-arms the vote
            if (div_wrap) begin
               s_next.div_cnt = ZERO16;
               s_next.bit_tick = 1'b1;
               s_next.vote_cnt = 2'h0;
            end else begin
               s_next.div_cnt = s_reg.div_cnt + 16'h0001;
            end
         end else begin
            s_next.pre_cnt = s_reg.pre_cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         s_reg <= '0;
         s_reg.tx_ctrl <= TX_CTRL_RESET;
         s_reg.rx_ctrl <= RX_CTRL_RESET;
         s_reg.rate_ctrl <= RATE_CTRL_RESET;
         s_reg.div_high <= DIV_RESET;
         s_reg.div_low <= DIV_RESET;
         s_reg.rx_pipe <= 3'h7;
         s_reg.samples <= 3'h7;
         s_reg.rx_level <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rdata = s_reg.rdata;
   assign o_bit_tick = s_reg.bit_tick;
   assign o_sample_tick = s_reg.sample_tick;
   assign o_rx_level = s_reg.rx_level;
endmodule
